// File: hdl/ser_pkg.sv
// constants shared by the status event reporting block
package ser_pkg;

  // register set widths
  localparam int unsigned STB_W = 8;
  localparam int unsigned STD_W = 8;
  localparam int unsigned OPER_W = 16;
  localparam int unsigned QUES_W = 16;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets on the apb bus
  localparam logic [ADDR_W-1:0] ADDR_STB = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SRE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STD_EVT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STD_EN = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_OPER_COND = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_OPER_EVT = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_OPER_EN = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_QUES_COND = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_QUES_EVT = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_QUES_EN = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR_STATUS = 8'h28;

  // status byte bit positions
  localparam int unsigned STB_OPER_SUM = 7;
  localparam int unsigned STB_MSS = 6;
  localparam int unsigned STB_STD_SUM = 5;
  localparam int unsigned STB_MSG_AVAIL = 4;
  localparam int unsigned STB_QUES_SUM = 3;

  // reset values
  localparam logic [STB_W-1:0] SRE_RST = 8'h00;
  localparam logic [STD_W-1:0] STD_EN_RST = 8'h00;
  localparam logic [OPER_W-1:0] OPER_EN_RST = 16'h0000;
  localparam logic [QUES_W-1:0] QUES_EN_RST = 16'h0000;
  localparam logic [31:0] PRDATA_RST = 32'h00000000;

endpackage

// File: hdl/ser_event_latch.sv
// one latching event register with enable mask and summary output
`timescale 1ns/1ps
module ser_event_latch #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // event set, clear and mask
  input wire logic [W-1:0] set_in,
  input wire logic clr,
  input wire logic [W-1:0] enable,
  // latched events and summary
  output logic [W-1:0] event_q,
  output logic summary
);

  typedef struct packed {
    logic [W-1:0] evt_r;
  } ser_latch_state_t;

  ser_latch_state_t st_r;
  ser_latch_state_t st_nxt;

  // latch events, a set in the clear cycle survives the clear
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.evt_r = set_in;
    end else begin
      st_nxt.evt_r = st_r.evt_r | set_in;
    end
  end

  // power-on clears every event bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign event_q = st_r.evt_r;
  assign summary = |(st_r.evt_r & enable);

  a_latch_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (!clr && (st_r.evt_r != '0)) |=> ((st_r.evt_r & $past(st_r.evt_r)) == $past(st_r.evt_r)))
    else $error("latched event bit dropped without a clear");

endmodule

// File: hdl/ser_top.sv
// status byte, service request enable and three event register sets behind apb
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module ser_top
  import ser_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instrument status sources, same clock
  input wire logic [STD_W-1:0] std_event_in,
  input wire logic [OPER_W-1:0] oper_cond_in,
  input wire logic [QUES_W-1:0] ques_cond_in,
  input wire logic msg_avail_in,
  // status outputs
  output logic [STB_W-1:0] status_byte,
  output logic mss
);

  typedef struct packed {
    logic [STB_W-1:0] sre_r;
    logic [STD_W-1:0] std_en_r;
    logic [OPER_W-1:0] oper_en_r;
    logic [QUES_W-1:0] ques_en_r;
    logic [OPER_W-1:0] oper_prev_r;
    logic [QUES_W-1:0] ques_prev_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [STB_W-1:0] stb_r;
    logic mss_r;
  } ser_state_t;

  ser_state_t st_r;
  ser_state_t st_nxt;

  // true for every mapped offset
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_STB, ADDR_SRE, ADDR_STD_EVT, ADDR_STD_EN, ADDR_OPER_COND, ADDR_OPER_EVT,
      ADDR_OPER_EN, ADDR_QUES_COND, ADDR_QUES_EVT, ADDR_QUES_EN, ADDR_CLEAR_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // true for offsets that accept a write
  function automatic logic is_writable(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_SRE, ADDR_STD_EN, ADDR_OPER_EN, ADDR_QUES_EN, ADDR_CLEAR_STATUS: is_writable = 1'b1;
      default: is_writable = 1'b0;
    endcase
  endfunction

  // apb phase decode
  logic setup_ph;
  logic access_ph;
  logic rd_setup;
  logic wr_access;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign rd_setup = setup_ph & ~pwrite;
  assign wr_access = access_ph & pwrite;

  // read-clear strobes fire with the data capture, so no event slips between
  logic clr_std;
  logic clr_oper;
  logic clr_ques;
  logic clear_status;
  assign clear_status = wr_access & (paddr == ADDR_CLEAR_STATUS);
  assign clr_std = (rd_setup & (paddr == ADDR_STD_EVT)) | clear_status;
  assign clr_oper = (rd_setup & (paddr == ADDR_OPER_EVT)) | clear_status;
  assign clr_ques = (rd_setup & (paddr == ADDR_QUES_EVT)) | clear_status;

  // operation and questionable events latch on rising condition edges
  logic [OPER_W-1:0] oper_set;
  logic [QUES_W-1:0] ques_set;
  assign oper_set = oper_cond_in & ~st_r.oper_prev_r;
  assign ques_set = ques_cond_in & ~st_r.ques_prev_r;

  // the three event register sets
  logic [STD_W-1:0] std_evt;
  logic [OPER_W-1:0] oper_evt;
  logic [QUES_W-1:0] ques_evt;
  logic std_sum;
  logic oper_sum;
  logic ques_sum;

  ser_event_latch #(
    .W(STD_W)
  ) u_std (
    .clk(pclk),
    .rst_n(presetn),
    .set_in(std_event_in),
    .clr(clr_std),
    .enable(st_r.std_en_r),
    .event_q(std_evt),
    .summary(std_sum)
  );

  ser_event_latch #(
    .W(OPER_W)
  ) u_oper (
    .clk(pclk),
    .rst_n(presetn),
    .set_in(oper_set),
    .clr(clr_oper),
    .enable(st_r.oper_en_r),
    .event_q(oper_evt),
    .summary(oper_sum)
  );

  ser_event_latch #(
    .W(QUES_W)
  ) u_ques (
    .clk(pclk),
    .rst_n(presetn),
    .set_in(ques_set),
    .clr(clr_ques),
    .enable(st_r.ques_en_r),
    .event_q(ques_evt),
    .summary(ques_sum)
  );

  // summary vector without the master bit
  logic [STB_W-1:0] sum_vec;
  logic mss_c;
  always_comb begin
    sum_vec = '0;
    sum_vec[STB_OPER_SUM] = oper_sum;
    sum_vec[STB_STD_SUM] = std_sum;
    sum_vec[STB_MSG_AVAIL] = msg_avail_in;
    sum_vec[STB_QUES_SUM] = ques_sum;
  end
  assign mss_c = |(sum_vec & st_r.sre_r);

  // read value as a binary-weighted word
  logic [31:0] rd_val;
  always_comb begin
    rd_val = PRDATA_RST;
    unique case (paddr)
      ADDR_STB: rd_val = {24'h000000, sum_vec | ({{(STB_W-1){1'b0}}, mss_c} << STB_MSS)};
      ADDR_SRE: rd_val = {24'h000000, st_r.sre_r};
      ADDR_STD_EVT: rd_val = {24'h000000, std_evt};
      ADDR_STD_EN: rd_val = {24'h000000, st_r.std_en_r};
      ADDR_OPER_COND: rd_val = {16'h0000, oper_cond_in};
      ADDR_OPER_EVT: rd_val = {16'h0000, oper_evt};
      ADDR_OPER_EN: rd_val = {16'h0000, st_r.oper_en_r};
      ADDR_QUES_COND: rd_val = {16'h0000, ques_cond_in};
      ADDR_QUES_EVT: rd_val = {16'h0000, ques_evt};
      ADDR_QUES_EN: rd_val = {16'h0000, st_r.ques_en_r};
      default: rd_val = PRDATA_RST;
    endcase
  end

  // next state: bus capture, enable writes, edge history, status byte
  always_comb begin
    st_nxt = st_r;
    st_nxt.oper_prev_r = oper_cond_in;
    st_nxt.ques_prev_r = ques_cond_in;
    if (setup_ph) begin
      st_nxt.prdata_r = pwrite ? PRDATA_RST : rd_val;
      st_nxt.pslverr_r = ~is_mapped(paddr) | (pwrite & ~is_writable(paddr));
    end
    if (wr_access) begin
      unique case (paddr)
        ADDR_SRE: st_nxt.sre_r = pwdata[STB_W-1:0];
        ADDR_STD_EN: st_nxt.std_en_r = pwdata[STD_W-1:0];
        ADDR_OPER_EN: st_nxt.oper_en_r = pwdata[OPER_W-1:0];
        ADDR_QUES_EN: st_nxt.ques_en_r = pwdata[QUES_W-1:0];
        default: st_nxt.sre_r = st_r.sre_r;
      endcase
    end
    st_nxt.stb_r = sum_vec;
    st_nxt.mss_r = mss_c;
  end

  // power-on clears enables and the status byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.sre_r <= SRE_RST;
      st_r.std_en_r <= STD_EN_RST;
      st_r.oper_en_r <= OPER_EN_RST;
      st_r.ques_en_r <= QUES_EN_RST;
      st_r.oper_prev_r <= '0;
      st_r.ques_prev_r <= '0;
      st_r.prdata_r <= PRDATA_RST;
      st_r.pslverr_r <= 1'b0;
      st_r.stb_r <= '0;
      st_r.mss_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus and status outputs
  assign pready = 1'b1;
  assign prdata = st_r.prdata_r;
  assign pslverr = st_r.pslverr_r;
  assign mss = st_r.mss_r;
  always_comb begin
    status_byte = st_r.stb_r;
    status_byte[STB_MSS] = st_r.mss_r;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_std_read_setup;
    rd_setup && (paddr == ADDR_STD_EVT) && (std_event_in == '0);
  endsequence

  sequence s_std_gone_then_bit5_low;
    (std_evt == '0) ##1 !status_byte[STB_STD_SUM];
  endsequence

  sequence s_cls_quiet;
    clear_status && (std_event_in == '0) && (oper_set == '0) && (ques_set == '0);
  endsequence

  a_mss_and_or: assert property (
    1'b1 |=> (mss == |($past(sum_vec) & $past(st_r.sre_r))))
    else $error("master summary not the masked OR of summary bits");

  a_esr_read_clear: assert property (
    s_std_read_setup |=> s_std_gone_then_bit5_low)
    else $error("standard event read did not clear register and bit 5");

  a_clear_win_set: assert property (
    clr_std && (std_event_in != '0) |=> ((std_evt & $past(std_event_in)) == $past(std_event_in)))
    else $error("event lost in the clear cycle");

  a_cls_all_clear: assert property (
    s_cls_quiet |=> (std_evt == '0) && (oper_evt == '0) && (ques_evt == '0)
      ##1 !status_byte[STB_STD_SUM] && !status_byte[STB_OPER_SUM] && !status_byte[STB_QUES_SUM])
    else $error("clear-status left an event or summary set");

  a_sre_write_read: assert property (
    wr_access && (paddr == ADDR_SRE) ##1 rd_setup && (paddr == ADDR_SRE)
      |=> (prdata == {24'h000000, $past(pwdata[STB_W-1:0], 2)}))
    else $error("service request enable did not read back");

  a_ro_write_refused: assert property (
    setup_ph && pwrite && (paddr == ADDR_STB) |=> pslverr ##1 (st_r.sre_r == $past(st_r.sre_r, 2)))
    else $error("write to read-only register not refused");

  a_oper_edge_latch: assert property (
    (oper_cond_in != '0) && !clr_oper |=> ((oper_evt & $past(oper_set)) == $past(oper_set)))
    else $error("operation event did not latch on condition edge");

  a_stb_no_clear: assert property (
    rd_setup && (paddr == ADDR_STB) && mss_c && (std_event_in == '0) && !clear_status |=> mss)
    else $error("status byte read cleared master summary");

  a_summary_bits: assert property (
    1'b1 |=> (status_byte[STB_OPER_SUM] == $past(|(oper_evt & st_r.oper_en_r)))
      && (status_byte[STB_MSG_AVAIL] == $past(msg_avail_in)))
    else $error("status byte summary bits wrong");

  // host write that must leave event state alone, live condition reads, event read value and read-clear
  a_evt_no_write: assert property (
    wr_access && (paddr == ADDR_STD_EVT) && (std_event_in == '0) |=> (std_evt == $past(std_evt)))
    else $error("host write changed the standard event register");

  a_cond_read_live: assert property (
    rd_setup && (paddr == ADDR_OPER_COND) |=> (prdata == {16'h0000, $past(oper_cond_in)}))
    else $error("operation condition read did not show live status");

  a_ques_cond_live: assert property (
    rd_setup && (paddr == ADDR_QUES_COND) |=> (prdata == {16'h0000, $past(ques_cond_in)}))
    else $error("questionable condition read did not show live status");

  a_std_read_value: assert property (
    rd_setup && (paddr == ADDR_STD_EVT) |=> (prdata == {24'h000000, $past(std_evt)}))
    else $error("standard event read value not the weighted register value");

  a_oper_read_clear: assert property (
    rd_setup && (paddr == ADDR_OPER_EVT) && (oper_set == '0) |=> (oper_evt == '0))
    else $error("operation event read did not clear the register");

  sequence s_ques_read_setup;
    rd_setup && (paddr == ADDR_QUES_EVT) && (ques_set == '0);
  endsequence

  a_ques_read_clear: assert property (
    s_ques_read_setup |=> (ques_evt == '0))
    else $error("questionable event read did not clear the register");

  // enable programming, zero clear and survival across clear-status
  a_std_en_decode: assert property (
    wr_access && (paddr == ADDR_STD_EN) |=> (st_r.std_en_r == $past(pwdata[STD_W-1:0])))
    else $error("standard enable not decoded from written value");

  a_ques_en_decode: assert property (
    wr_access && (paddr == ADDR_QUES_EN) |=> (st_r.ques_en_r == $past(pwdata[QUES_W-1:0])))
    else $error("questionable enable not decoded from written value");

  a_oper_en_read: assert property (
    rd_setup && (paddr == ADDR_OPER_EN) |=> (prdata == {16'h0000, $past(st_r.oper_en_r)}))
    else $error("operation enable did not read back");

  a_sre_zero_clear: assert property (
    wr_access && (paddr == ADDR_SRE) && (pwdata[STB_W-1:0] == '0) |=> (st_r.sre_r == '0))
    else $error("writing zero did not clear the request enable");

  a_cls_en_kept: assert property (
    clear_status |=> (st_r.sre_r == $past(st_r.sre_r)) && (st_r.std_en_r == $past(st_r.std_en_r)))
    else $error("clear-status disturbed an enable register");

  // enabled standard event latches, then raises its summary bit
  sequence s_std_enabled_pulse;
    ((std_event_in & st_r.std_en_r) != '0) && !(wr_access && (paddr == ADDR_STD_EN));
  endsequence

  sequence s_std_latched_then_sum;
    ((std_evt & $past(std_event_in)) != '0) ##1 status_byte[STB_STD_SUM];
  endsequence

  a_std_sum_follow: assert property (
    s_std_enabled_pulse |=> s_std_latched_then_sum)
    else $error("enabled standard event did not raise its summary bit");

endmodule

// File: testbench/ser_src_model.sv
// instrument status source model driving the block's status inputs
`timescale 1ns/1ps
module ser_src_model
  import ser_pkg::*;
(
  // clock
  input wire logic pclk,
  // instrument status toward the block
  output logic [STD_W-1:0] std_event_in,
  output logic [OPER_W-1:0] oper_cond_in,
  output logic [QUES_W-1:0] ques_cond_in,
  output logic msg_avail_in
);
  // quiet sources from time zero
  initial begin
    std_event_in = 8'h00;
    oper_cond_in = 16'h0000;
    ques_cond_in = 16'h0000;
    msg_avail_in = 1'b0;
  end

  // one-cycle event pulse, launched after a rising edge
  task automatic pulse_std(input logic [STD_W-1:0] m);
    @(posedge pclk);
    std_event_in <= m;
    @(posedge pclk);
    std_event_in <= 8'h00;
  endtask

  // live status levels, held until changed
  task automatic set_levels(input logic [OPER_W-1:0] o, input logic [QUES_W-1:0] q, input logic m);
    @(posedge pclk);
    oper_cond_in <= o;
    ques_cond_in <= q;
    msg_avail_in <= m;
  endtask
endmodule

// File: testbench/tb_status_event_reporting.sv
// self-checking testbench for the status event reporting block
`timescale 1ns/1ps
module tb_status_event_reporting
  import ser_pkg::*;
;
  // apb and status signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [STD_W-1:0] std_event_in;
  logic [OPER_W-1:0] oper_cond_in;
  logic [QUES_W-1:0] ques_cond_in;
  logic msg_avail_in;
  logic [STB_W-1:0] status_byte;
  logic mss;
  int failures = 0;
  int checks_done = 0;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // far-side status sources
  ser_src_model u_src (.pclk(pclk), .std_event_in(std_event_in), .oper_cond_in(oper_cond_in),
    .ques_cond_in(ques_cond_in), .msg_avail_in(msg_avail_in));

  // block under test
  ser_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .std_event_in(std_event_in), .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in),
    .msg_avail_in(msg_avail_in), .status_byte(status_byte), .mss(mss));

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read and compare data and error
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, eexp});
  endtask

  // write and compare error
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, {31'h0, eexp});
  endtask

  // let status outputs settle, then compare status byte and master summary
  task automatic sb(input logic [7:0] exp);
    repeat (3) @(posedge pclk);
    check({24'h0, status_byte}, {24'h0, exp});
    check({31'h0, mss}, {31'h0, exp[6]});
  endtask

  // power-on values and unmapped access
  task automatic t_reset();
    rd(ADDR_SRE, 32'h0, 1'b0);
    rd(ADDR_STD_EN, 32'h0, 1'b0);
    rd(ADDR_OPER_EN, 32'h0, 1'b0);
    rd(ADDR_QUES_EN, 32'h0, 1'b0);
    rd(ADDR_STD_EVT, 32'h0, 1'b0);
    rd(ADDR_STB, 32'h0, 1'b0);
    rd(8'h2C, 32'h0, 1'b1);
    sb(8'h00);
  endtask

  // enable programming and readback, weighted values
  task automatic t_enables();
    wr(ADDR_SRE, 32'h000000B8, 1'b0);
    wr(ADDR_STD_EN, 32'h000000A5, 1'b0);
    wr(ADDR_OPER_EN, 32'h00001460, 1'b0);
    wr(ADDR_QUES_EN, 32'h00000303, 1'b0);
    rd(ADDR_SRE, 32'h000000B8, 1'b0);
    rd(ADDR_STD_EN, 32'h000000A5, 1'b0);
    rd(ADDR_OPER_EN, 32'h00001460, 1'b0);
    rd(ADDR_QUES_EN, 32'h00000303, 1'b0);
  endtask

  // writes to read-only places are refused
  task automatic t_readonly();
    wr(ADDR_STB, 32'h000000FF, 1'b1);
    wr(ADDR_STD_EVT, 32'h000000FF, 1'b1);
    wr(ADDR_OPER_COND, 32'h0000FFFF, 1'b1);
    rd(ADDR_STD_EVT, 32'h0, 1'b0);
    rd(ADDR_OPER_COND, 32'h0, 1'b0);
    sb(8'h00);
  endtask

  // standard events latch, summarise and clear on read
  task automatic t_std();
    u_src.pulse_std(8'h05);
    u_src.pulse_std(8'h05);
    u_src.pulse_std(8'h02);
    sb(8'h60);
    rd(ADDR_STB, 32'h00000060, 1'b0);
    rd(ADDR_STB, 32'h00000060, 1'b0);
    rd(ADDR_STD_EVT, 32'h00000007, 1'b0);
    sb(8'h00);
    rd(ADDR_STD_EVT, 32'h0, 1'b0);
  endtask

  // conditions, clear-status and read-clear of operation events
  task automatic t_cond();
    u_src.set_levels(16'h1000, 16'h0001, 1'b1);
    sb(8'hD8);
    rd(ADDR_OPER_COND, 32'h00001000, 1'b0);
    rd(ADDR_QUES_COND, 32'h00000001, 1'b0);
    wr(ADDR_CLEAR_STATUS, 32'h00000001, 1'b0);
    sb(8'h50);
    rd(ADDR_OPER_EVT, 32'h0, 1'b0);
    rd(ADDR_QUES_EVT, 32'h0, 1'b0);
    rd(ADDR_OPER_COND, 32'h00001000, 1'b0);
    u_src.set_levels(16'h0400, 16'h0001, 1'b1);
    rd(ADDR_OPER_EVT, 32'h00000400, 1'b0);
    rd(ADDR_OPER_EVT, 32'h0, 1'b0);
    wr(ADDR_SRE, 32'h00000000, 1'b0);
    sb(8'h10);
  endtask

  // event arriving in the read-clear cycle survives
  task automatic t_race();
    fork
      rd(ADDR_STD_EVT, 32'h0, 1'b0);
      u_src.pulse_std(8'h01);
    join
    rd(ADDR_STD_EVT, 32'h00000001, 1'b0);
  endtask

  // request enable write then read back to back, psel held high between
  task automatic t_b2b();
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'b1;
    paddr <= ADDR_SRE;
    pwdata <= 32'h00000018;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check({31'h0, pslverr}, 32'h00000000);
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h00000000;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check(prdata, 32'h00000018);
    psel <= 1'b0;
    penable <= 1'b0;
    sb(8'h50);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_enables();
    t_readonly();
    t_std();
    t_cond();
    t_race();
    t_b2b();
    conclude();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    conclude();
  end
endmodule
